// ==== hfc_pkg.sv ====
// shared constants and types of the hci uart with hardware flow control
// Behaviour
// - per-byte accumulated baud error stays within -2.5 % and +1.5 % of nominal.
// - timing deviation within one bit stays within plus or minus 12.5 %.
// - after cts returns low, transmission resumes within about 2 us.
// - once cts goes high, at most one more byte is sent.
// - host stops within 16 bytes of rts high; receiver keeps room for them.
// - out of reset the link runs 115.2 kbps, 8 data bits, 1 stop, no parity.
// - rate change takes effect only after the completion event is sent at old rate.
// - rts goes high when receive fill level passes the threshold.
// - detect break, idle, framing, overflow, parity and underflow conditions.
package hfc_pkg;

    // ************************************************************
    // clock and rates
    // ************************************************************
    localparam int CLK_HZ        = 32'h05F5_E100;  // 100 MHz
    localparam int CLK_PERIOD_NS = 32'h0000_000A;
    localparam int DEF_BAUD      = 32'h0001_C200;  // 115200
    localparam int MIN_BAUD      = 32'h0000_927C;  // 37500
    localparam int MAX_BAUD      = 32'h0042_96E0;  // 4364000
    localparam logic [15:0] DEF_DIV = 16'(CLK_HZ / DEF_BAUD);
    localparam logic [15:0] MIN_DIV = 16'(CLK_HZ / MAX_BAUD);
    localparam logic [15:0] MAX_DIV = 16'(CLK_HZ / MIN_BAUD);

    // ************************************************************
    // frame and flow control
    // ************************************************************
    localparam int DATA_BITS   = 32'h0000_0008;
    localparam int STOP_BITS   = 32'h0000_0001;
    localparam int FIFO_DEPTH  = 32'h0000_0040;
    localparam int RX_THR_FRAC = 32'h0000_0004;  // headroom is a quarter of the fifo
    localparam int RX_HEADROOM = 32'h0000_0010;  // bytes still in flight after rts
    localparam int IDLE_BITS   = 32'h0000_000A;
    localparam int RESUME_NS   = 32'h0000_07D0;  // 2000 ns
    localparam int RESUME_CYC  = (RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } hfc_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100,
        RX_WAIT  = 3'b101
    } hfc_rx_st_t;

    typedef struct packed {
        logic par_en;
        logic par_odd;
    } hfc_cfg_t;

    typedef struct packed {
        logic brk;
        logic idle;
        logic frame;
        logic ovf;
        logic par;
        logic udf;
    } hfc_err_t;

endpackage

// ==== hfc_ram.sv ====
// receive byte store with registered read data
`timescale 1ns/1ps
module hfc_ram #(
    parameter int W     = 8,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          sys_clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [W-1:0]  wdata_i,
    input  wire logic          re_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [W-1:0]  rdata_o
);

    logic [W-1:0] mem [DEPTH];

    // no reset on the array; contents are only read after a write
    always_ff @(posedge sys_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule

// ==== hfc_uart.sv ====
// hci uart core: 8-bit framing, cts/rts flow control, rate change, error flags
`timescale 1ns/1ps
module hfc_uart #(
    parameter int DEPTH     = hfc_pkg::FIFO_DEPTH,
    parameter int IDLE_BITS = hfc_pkg::IDLE_BITS
) (
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    output logic                   tx_o,
    input  wire logic              rx_i,
    input  wire logic              cts_i,
    output logic                   rts_o,
    input  wire logic [7:0]        tx_data_i,
    input  wire logic              tx_last_i,
    input  wire logic              tx_valid_i,
    output logic                   tx_ready_o,
    input  wire hfc_pkg::hfc_cfg_t cfg_i,
    input  wire logic [15:0]       baud_div_i,
    input  wire logic              baud_req_i,
    output logic      [15:0]       baud_div_o,
    input  wire logic              rx_rd_i,
    output logic      [7:0]        rx_data_o,
    output logic                   rx_valid_o,
    output logic [$clog2(DEPTH):0] rx_level_o,
    output hfc_pkg::hfc_err_t      err_o
);

    localparam int AW  = $clog2(DEPTH);
    localparam int AW1 = AW + 1;
    // one below three quarters: the byte that raises rts is already stored,
    // so a full quarter of the fifo is still free for the host's late bytes
    localparam logic [AW:0] THR    = AW1'(DEPTH - DEPTH / hfc_pkg::RX_THR_FRAC - 1);
    localparam logic [AW:0] FULL   = AW1'(DEPTH);
    localparam logic [7:0]  IDLE_N = 8'(IDLE_BITS - 1);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic bit_end(input logic [15:0] cnt, input logic [15:0] div);
        return cnt == div - 16'h0001;
    endfunction

    function automatic logic par_of(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

    // ************************************************************
    // transmitter and rate control
    // ************************************************************
    hfc_pkg::hfc_tx_st_t tx_st_q, tx_st_d;
    logic [15:0] tx_cnt_q, tx_cnt_d, div_q, div_d, new_div_q, new_div_d;
    logic [2:0]  tx_bit_q, tx_bit_d;
    logic [7:0]  tx_sh_q, tx_sh_d;
    logic        tx_par_q, tx_par_d, tx_last_q, tx_last_d, tx_q, tx_d;
    logic        rdy_q, rdy_d, pend_q, pend_d, chg_q, chg_d;
    logic        tx_done, apply_baud;

    always_comb begin
        tx_st_d   = tx_st_q;
        tx_cnt_d  = tx_cnt_q + 16'h0001;
        tx_bit_d  = tx_bit_q;
        tx_sh_d   = tx_sh_q;
        tx_par_d  = tx_par_q;
        tx_last_d = tx_last_q;
        tx_done   = 1'b0;
        case (tx_st_q)
            hfc_pkg::TX_IDLE: begin
                tx_cnt_d = '0;
                if (tx_valid_i && rdy_q) begin
                    tx_sh_d   = tx_data_i;
                    tx_last_d = tx_last_i;
                    tx_par_d  = par_of(tx_data_i, cfg_i.par_odd);
                    tx_st_d   = hfc_pkg::TX_START;
                end
            end
            hfc_pkg::TX_START: begin
                if (bit_end(tx_cnt_q, div_q)) begin
                    tx_cnt_d = '0;
                    tx_bit_d = '0;
                    tx_st_d  = hfc_pkg::TX_DATA;
                end
            end
            hfc_pkg::TX_DATA: begin
                if (bit_end(tx_cnt_q, div_q)) begin
                    tx_cnt_d = '0;
                    tx_sh_d  = tx_sh_q >> 1;
                    tx_bit_d = tx_bit_q + 3'h1;
                    if (tx_bit_q == 3'h7) begin
                        tx_st_d = cfg_i.par_en ? hfc_pkg::TX_PAR : hfc_pkg::TX_STOP;
                    end
                end
            end
            hfc_pkg::TX_PAR: begin
                if (bit_end(tx_cnt_q, div_q)) begin
                    tx_cnt_d = '0;
                    tx_st_d  = hfc_pkg::TX_STOP;
                end
            end
            hfc_pkg::TX_STOP: begin
                if (bit_end(tx_cnt_q, div_q)) begin
                    tx_cnt_d = '0;
                    tx_done  = 1'b1;
                    tx_st_d  = hfc_pkg::TX_IDLE;
                end
            end
            default: begin
                tx_st_d = hfc_pkg::TX_IDLE;
            end
        endcase
        case (tx_st_d)
            hfc_pkg::TX_START: tx_d = 1'b0;
            hfc_pkg::TX_DATA:  tx_d = tx_sh_d[0];
            hfc_pkg::TX_PAR:   tx_d = tx_par_d;
            default:           tx_d = 1'b1;
        endcase
        // cts is only looked at between bytes, so a byte in progress always completes
        rdy_d = (tx_st_d == hfc_pkg::TX_IDLE) && !cts_i;
        // the new divisor waits for the last byte of the completion event
        apply_baud = tx_done && tx_last_q && pend_q;
        div_d      = div_q;
        pend_d     = pend_q;
        new_div_d  = new_div_q;
        chg_d      = chg_q;
        if (apply_baud) begin
            div_d  = new_div_q;
            pend_d = 1'b0;
            chg_d  = 1'b1;
        end
        if (baud_req_i) begin
            pend_d = 1'b1;
            if (baud_div_i < hfc_pkg::MIN_DIV) begin
                new_div_d = hfc_pkg::MIN_DIV;
            end else if (baud_div_i > hfc_pkg::MAX_DIV) begin
                new_div_d = hfc_pkg::MAX_DIV;
            end else begin
                new_div_d = baud_div_i;
            end
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    hfc_pkg::hfc_rx_st_t rx_st_q, rx_st_d;
    logic [15:0] rx_cnt_q, rx_cnt_d;
    logic [2:0]  rx_bit_q, rx_bit_d;
    logic [7:0]  rx_sh_q, rx_sh_d, idle_n_q, idle_n_d;
    logic        pbad_q, pbad_d, armed_q, armed_d;
    logic        rx_wr, e_brk, e_idle, e_frame, e_par;

    always_comb begin
        rx_st_d  = rx_st_q;
        rx_cnt_d = rx_cnt_q + 16'h0001;
        rx_bit_d = rx_bit_q;
        rx_sh_d  = rx_sh_q;
        idle_n_d = idle_n_q;
        pbad_d   = pbad_q;
        armed_d  = armed_q;
        rx_wr    = 1'b0;
        e_brk    = 1'b0;
        e_idle   = 1'b0;
        e_frame  = 1'b0;
        e_par    = 1'b0;
        case (rx_st_q)
            hfc_pkg::RX_IDLE: begin
                if (!rx_i) begin
                    rx_cnt_d = '0;
                    idle_n_d = '0;
                    pbad_d   = 1'b0;
                    rx_st_d  = hfc_pkg::RX_START;
                end else if (bit_end(rx_cnt_q, div_q)) begin
                    rx_cnt_d = '0;
                    if (idle_n_q != IDLE_N) begin
                        idle_n_d = idle_n_q + 8'h01;
                    end else if (armed_q) begin
                        e_idle  = 1'b1;
                        armed_d = 1'b0;
                    end
                end
            end
            hfc_pkg::RX_START: begin
                // later samples fall mid-bit, leaving half a bit of margin each way
                if (rx_cnt_q == (div_q >> 1)) begin
                    rx_cnt_d = '0;
                    rx_bit_d = '0;
                    rx_st_d  = rx_i ? hfc_pkg::RX_IDLE : hfc_pkg::RX_DATA;
                end
            end
            hfc_pkg::RX_DATA: begin
                if (bit_end(rx_cnt_q, div_q)) begin
                    rx_cnt_d = '0;
                    rx_sh_d  = {rx_i, rx_sh_q[7:1]};
                    rx_bit_d = rx_bit_q + 3'h1;
                    if (rx_bit_q == 3'h7) begin
                        rx_st_d = cfg_i.par_en ? hfc_pkg::RX_PAR : hfc_pkg::RX_STOP;
                    end
                end
            end
            hfc_pkg::RX_PAR: begin
                if (bit_end(rx_cnt_q, div_q)) begin
                    rx_cnt_d = '0;
                    pbad_d   = rx_i != par_of(rx_sh_q, cfg_i.par_odd);
                    rx_st_d  = hfc_pkg::RX_STOP;
                end
            end
            hfc_pkg::RX_STOP: begin
                if (bit_end(rx_cnt_q, div_q)) begin
                    rx_cnt_d = '0;
                    if (rx_i) begin
                        rx_wr   = 1'b1;
                        e_par   = pbad_q;
                        armed_d = 1'b1;
                        rx_st_d = hfc_pkg::RX_IDLE;
                    end else begin
                        e_brk   = rx_sh_q == 8'h00;
                        e_frame = rx_sh_q != 8'h00;
                        rx_st_d = hfc_pkg::RX_WAIT;
                    end
                end
            end
            hfc_pkg::RX_WAIT: begin
                // hold off until the line is released, else a break restarts frames
                if (rx_i) begin
                    rx_cnt_d = '0;
                    rx_st_d  = hfc_pkg::RX_IDLE;
                end
            end
            default: begin
                rx_st_d = hfc_pkg::RX_IDLE;
            end
        endcase
    end

    // ************************************************************
    // receive fifo and rts
    // ************************************************************
    logic [AW:0] wp_q, wp_d, rp_q, rp_d, lvl_d;
    logic        wr_ok, rd_ok, vld_d, rts_d;
    hfc_pkg::hfc_err_t err_d;

    always_comb begin
        wr_ok = rx_wr && (rx_level_o != FULL);
        rd_ok = rx_rd_i && (rx_level_o != '0);
        wp_d  = wr_ok ? wp_q + 1'b1 : wp_q;
        rp_d  = rd_ok ? rp_q + 1'b1 : rp_q;
        lvl_d = wp_d - rp_d;
        vld_d = rd_ok;
        // rts rises with room for the bytes the host still has in flight
        rts_d = lvl_d > THR;
        err_d.brk   = e_brk;
        err_d.idle  = e_idle;
        err_d.frame = e_frame;
        err_d.ovf   = rx_wr && (rx_level_o == FULL);
        err_d.par   = e_par;
        err_d.udf   = rx_rd_i && (rx_level_o == '0);
    end

    hfc_ram #(
        .W     (hfc_pkg::DATA_BITS),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) i_hfc_ram (
        .sys_clk_i (sys_clk_i),
        .we_i      (wr_ok),
        .waddr_i   (wp_q[AW-1:0]),
        .wdata_i   (rx_sh_q),
        .re_i      (rd_ok),
        .raddr_i   (rp_q[AW-1:0]),
        .rdata_o   (rx_data_o)
    );

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_q    <= hfc_pkg::TX_IDLE;
            tx_cnt_q   <= '0;
            tx_bit_q   <= '0;
            tx_sh_q    <= '0;
            tx_par_q   <= 1'b0;
            tx_last_q  <= 1'b0;
            tx_q       <= 1'b1;
            rdy_q      <= 1'b0;
            div_q      <= hfc_pkg::DEF_DIV;
            new_div_q  <= hfc_pkg::DEF_DIV;
            pend_q     <= 1'b0;
            chg_q      <= 1'b0;
            rx_st_q    <= hfc_pkg::RX_IDLE;
            rx_cnt_q   <= '0;
            rx_bit_q   <= '0;
            rx_sh_q    <= '0;
            idle_n_q   <= '0;
            pbad_q     <= 1'b0;
            armed_q    <= 1'b0;
            wp_q       <= '0;
            rp_q       <= '0;
            rx_level_o <= '0;
            rx_valid_o <= 1'b0;
            rts_o      <= 1'b0;
            err_o      <= '0;
        end else begin
            tx_st_q    <= tx_st_d;
            tx_cnt_q   <= tx_cnt_d;
            tx_bit_q   <= tx_bit_d;
            tx_sh_q    <= tx_sh_d;
            tx_par_q   <= tx_par_d;
            tx_last_q  <= tx_last_d;
            tx_q       <= tx_d;
            rdy_q      <= rdy_d;
            div_q      <= div_d;
            new_div_q  <= new_div_d;
            pend_q     <= pend_d;
            chg_q      <= chg_d;
            rx_st_q    <= rx_st_d;
            rx_cnt_q   <= rx_cnt_d;
            rx_bit_q   <= rx_bit_d;
            rx_sh_q    <= rx_sh_d;
            idle_n_q   <= idle_n_d;
            pbad_q     <= pbad_d;
            armed_q    <= armed_d;
            wp_q       <= wp_d;
            rp_q       <= rp_d;
            rx_level_o <= lvl_d;
            rx_valid_o <= vld_d;
            rts_o      <= rts_d;
            err_o      <= err_d;
        end
    end

    assign tx_o       = tx_q;
    assign tx_ready_o = rdy_q;
    assign baud_div_o = div_q;

    // ************************************************************
    // assertions
    // ************************************************************
    localparam int RESUME_MAX = hfc_pkg::RESUME_CYC;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    cts_resume_a: assert property (
        (tx_st_q == hfc_pkg::TX_IDLE && !cts_i && tx_valid_i) [*2]
        |-> ##[1:RESUME_MAX] (tx_st_q == hfc_pkg::TX_START))
        else $error("transmit did not resume after cts low");

    cts_hold_a: assert property (
        $past(cts_i) && cts_i && tx_st_q == hfc_pkg::TX_IDLE
        |=> tx_st_q == hfc_pkg::TX_IDLE)
        else $error("byte started while cts high");

    rts_thr_a: assert property (
        rx_level_o > THR |-> rts_o)
        else $error("rts low above threshold");

    rts_room_a: assert property (
        !rts_o |-> (DEPTH - int'(rx_level_o)) > hfc_pkg::RX_HEADROOM)
        else $error("rts low without headroom");

    def_baud_a: assert property (
        !chg_q |-> div_q == hfc_pkg::DEF_DIV)
        else $error("divisor left default without a change");

    baud_switch_a: assert property (
        div_q != $past(div_q) |-> $past(apply_baud))
        else $error("divisor changed outside last byte end");

    stop_err_a: assert property (
        rx_st_q == hfc_pkg::RX_STOP && bit_end(rx_cnt_q, div_q) && !rx_i
        |=> (err_o.frame || err_o.brk) && rx_st_q == hfc_pkg::RX_WAIT)
        else $error("low stop bit not flagged");

    ovf_flag_a: assert property (
        rx_wr && rx_level_o == FULL |=> err_o.ovf)
        else $error("overflow not flagged");

    udf_flag_a: assert property (
        rx_rd_i && rx_level_o == '0 |=> err_o.udf && !rx_valid_o)
        else $error("underflow not flagged");

endmodule

// ==== hfc_host_model.sv ====
// host side of the hci link: serial frame sender and byte receiver
`timescale 1ns/1ps
module hfc_host_model (
    input  wire logic sys_clk_i,
    input  wire logic line_i,
    output logic      line_o = 1'b1
);
    int         div = int'(hfc_pkg::DEF_DIV);
    logic [8:0] got[$];

    // ************************************************************
    // sender: 11 bits lsb first, exact bit time, line left high
    // ************************************************************
    task automatic send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            @(negedge sys_clk_i);
            line_o = f[i];
            repeat (div - 1) @(negedge sys_clk_i);
        end
        @(negedge sys_clk_i);
        line_o = 1'b1;
    endtask

    // ************************************************************
    // receiver: mid-bit samples of 8 data bits and the stop bit
    // ************************************************************
    always begin : rx_frame
        logic [8:0] b;
        @(negedge line_i);
        repeat (div / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (div) @(posedge sys_clk_i);
            b[i] = line_i;
        end
        got.push_back(b);
    end
endmodule

// ==== tb_hfc_uart.sv ====
// self-checking bench for the hci uart core with flow control
`timescale 1ns/1ps
module tb_hfc_uart;
    localparam int DEPTH = hfc_pkg::FIFO_DEPTH;

    logic              sys_clk_i  = 1'b0;
    logic              rst_i      = 1'b1;
    logic              tx_o;
    logic              rx_i;
    logic              cts_i      = 1'b0;
    logic              rts_o;
    logic [7:0]        tx_data_i  = 8'h00;
    logic              tx_last_i  = 1'b0;
    logic              tx_valid_i = 1'b0;
    logic              tx_ready_o;
    hfc_pkg::hfc_cfg_t cfg_i      = '0;
    logic [15:0]       baud_div_i = 16'h0000;
    logic              baud_req_i = 1'b0;
    logic [15:0]       baud_div_o;
    logic              rx_rd_i    = 1'b0;
    logic [7:0]        rx_data_o;
    logic              rx_valid_o;
    logic [6:0]        rx_level_o;
    hfc_pkg::hfc_err_t err_o;
    hfc_pkg::hfc_err_t seen       = '0;
    logic              clr_q      = 1'b0;
    int                errors     = 0;
    int                checks     = 0;

    always #(hfc_pkg::CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;

    // error pulses are one cycle wide, so keep them until cleared
    always @(posedge sys_clk_i) seen <= clr_q ? err_o : (seen | err_o);

    hfc_uart i_hfc_uart (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .tx_o       (tx_o),
        .rx_i       (rx_i),
        .cts_i      (cts_i),
        .rts_o      (rts_o),
        .tx_data_i  (tx_data_i),
        .tx_last_i  (tx_last_i),
        .tx_valid_i (tx_valid_i),
        .tx_ready_o (tx_ready_o),
        .cfg_i      (cfg_i),
        .baud_div_i (baud_div_i),
        .baud_req_i (baud_req_i),
        .baud_div_o (baud_div_o),
        .rx_rd_i    (rx_rd_i),
        .rx_data_o  (rx_data_o),
        .rx_valid_o (rx_valid_o),
        .rx_level_o (rx_level_o),
        .err_o      (err_o)
    );

    hfc_host_model i_hfc_host_model (
        .sys_clk_i (sys_clk_i),
        .line_i    (tx_o),
        .line_o    (rx_i)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic give_up;
        chk(16'h0000, 16'h0001);
        wrap_up();
    endtask

    task automatic clr;
        @(negedge sys_clk_i);
        clr_q = 1'b1;
        @(negedge sys_clk_i);
        clr_q = 1'b0;
    endtask

    task automatic wait_rx(input int n);
        int k;
        for (k = 0; k < 20000; k++) begin
            if (i_hfc_host_model.got.size() >= n) break;
            @(posedge sys_clk_i);
        end
        if (k == 20000) give_up();
        @(negedge sys_clk_i);
    endtask

    task automatic send_tx(input logic [7:0] d, input logic last);
        int k;
        tx_data_i  = d;
        tx_last_i  = last;
        tx_valid_i = 1'b1;
        for (k = 0; k < 20000; k++) begin
            @(posedge sys_clk_i);
            if (tx_ready_o === 1'b1) break;
        end
        if (k == 20000) give_up();
        @(negedge sys_clk_i);
        tx_valid_i = 1'b0;
    endtask

    task automatic pop;
        rx_rd_i = 1'b1;
        @(negedge sys_clk_i);
        rx_rd_i = 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_rate;
        chk(baud_div_o, hfc_pkg::DEF_DIV);
        chk(16'(tx_o), 16'h0001);
        baud_div_i = 16'h0010;
        baud_req_i = 1'b1;
        @(negedge sys_clk_i);
        baud_req_i = 1'b0;
        send_tx(8'hA5, 1'b0);
        wait_rx(1);
        chk(16'(i_hfc_host_model.got[0]), 16'h01A5);
        chk(baud_div_o, hfc_pkg::DEF_DIV);
        send_tx(8'h3C, 1'b1);
        wait_rx(2);
        chk(16'(i_hfc_host_model.got[1]), 16'h013C);
        chk(baud_div_o, hfc_pkg::DEF_DIV);
        repeat (hfc_pkg::DEF_DIV) @(negedge sys_clk_i);
        chk(baud_div_o, hfc_pkg::MIN_DIV);
        i_hfc_host_model.div = int'(hfc_pkg::MIN_DIV);
    endtask

    task automatic t_cts;
        int k;
        int n;
        n          = i_hfc_host_model.got.size();
        cts_i      = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        tx_data_i  = 8'h5A;
        tx_valid_i = 1'b1;
        for (k = 0; k < 300; k++) begin
            @(negedge sys_clk_i);
            if (tx_o !== 1'b1 || tx_ready_o !== 1'b0) break;
        end
        chk(16'(k), 16'h012C);
        cts_i = 1'b0;
        for (k = 0; k < 1000; k++) begin
            @(negedge sys_clk_i);
            if (tx_o === 1'b0) break;
        end
        chk(16'(k <= hfc_pkg::RESUME_CYC), 16'h0001);
        tx_data_i = 8'hC3;
        repeat (50) @(negedge sys_clk_i);
        cts_i = 1'b1;
        repeat (400) @(negedge sys_clk_i);
        chk(16'(i_hfc_host_model.got.size() - n), 16'h0001);
        chk(16'(i_hfc_host_model.got[n]), 16'h015A);
        chk(16'(tx_o), 16'h0001);
        cts_i = 1'b0;
        wait_rx(n + 2);
        tx_valid_i = 1'b0;
        chk(16'(i_hfc_host_model.got[n + 1]), 16'h01C3);
    endtask

    task automatic t_fill;
        clr();
        // host overruns its allowance here on purpose to reach overflow
        for (int i = 0; i <= DEPTH; i++) begin
            i_hfc_host_model.send({2'b11, 8'(8'h30 + i), 1'b0});
            chk(16'(rx_level_o), 16'(i < DEPTH ? i + 1 : DEPTH));
            chk(16'(rts_o), 16'(i + 1 >= DEPTH - hfc_pkg::RX_HEADROOM));
        end
        chk(16'(seen.ovf), 16'h0001);
        for (int i = 0; i < DEPTH; i++) begin
            pop();
            chk(16'(rx_valid_o), 16'h0001);
            chk(16'(rx_data_o), 16'(8'h30 + i));
            @(negedge sys_clk_i);
        end
        chk(16'(rts_o), 16'h0000);
        clr();
        pop();
        chk(16'(rx_valid_o), 16'h0000);
        @(negedge sys_clk_i);
        chk(16'(seen.udf), 16'h0001);
        i_hfc_host_model.send({2'b11, 8'h77, 1'b0});
        chk(16'(rx_level_o), 16'h0001);
    endtask

    task automatic t_errs;
        int n;
        n = int'(rx_level_o);
        clr();
        i_hfc_host_model.send({2'b10, 8'h55, 1'b0});
        chk(16'(seen.frame), 16'h0001);
        chk(16'(rx_level_o), 16'(n));
        clr();
        i_hfc_host_model.send({2'b10, 8'h00, 1'b0});
        chk(16'(seen.brk), 16'h0001);
        cfg_i = '{par_en: 1'b1, par_odd: 1'b0};
        clr();
        // even parity of 8'h01 is 1, a 0 is sent instead
        i_hfc_host_model.send({2'b10, 8'h01, 1'b0});
        chk(16'(seen.par), 16'h0001);
        chk(16'(rx_level_o), 16'(n + 1));
        clr();
        repeat (12 * hfc_pkg::MIN_DIV) @(negedge sys_clk_i);
        chk(16'(seen.idle), 16'h0001);
        cfg_i = '{par_en: 1'b1, par_odd: 1'b1};
        clr();
        // odd parity of 8'h01 is 0, so this frame is clean
        i_hfc_host_model.send({2'b10, 8'h01, 1'b0});
        chk(16'(seen.par), 16'h0000);
        chk(16'(rx_level_o), 16'(n + 2));
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(negedge sys_clk_i);
        rst_i = 1'b0;
        @(negedge sys_clk_i);
        chk(16'(rts_o), 16'h0000);
        chk(16'(rx_level_o), 16'h0000);
        t_rate();
        t_cts();
        t_fill();
        t_errs();
        wrap_up();
    end
endmodule
